// *** hw/ahp_pkg.sv ***
// Purpose: shared constants and types of the analog output host RAM port
// Assumes: 256 x 16 internal RAM, byte-wide RAM addresses
// Notes:   bit positions refer to the allocated I/O words n..n+3
package ahp_pkg;

  localparam int          AHP_AW        = 8;
  localparam int          AHP_DW        = 16;
  localparam int          AHP_DEPTH     = 256;
  localparam logic [7:0]  AHP_PTR_ADDR  = 8'h0C;   // read pointer word
  localparam logic [7:0]  AHP_PARM_ADDR = 8'h00;   // parameter word fetched
  localparam logic [15:0] AHP_PTR_RESET = 16'h0000;
  localparam logic [8:0]  AHP_RAM_TOP   = 9'h100;  // one past last address

  // bit positions in word n+1 (host to device) and n+3 (device to host)
  localparam int AHP_BIT_RW   = 0;   // 1 write, 0 read
  localparam int AHP_BIT_REQ  = 6;   // request / address-taken acknowledge
  localparam int AHP_BIT_DAT  = 7;   // data taken / data ready
  localparam int AHP_ADDR_LSB = 8;

  typedef enum logic [2:0] {
    AHP_IDLE   = 3'b000,
    AHP_WCOL   = 3'b001,   // collecting block write words
    AHP_WCOPY  = 3'b010,   // copying checked words into RAM
    AHP_BRD    = 3'b011,   // block read streaming
    AHP_FWRD   = 3'b100,   // four-word read data return
    AHP_PFETCH = 3'b101    // parameter fetch after update
  } ahp_state_t;

  typedef struct packed {
    ahp_state_t  st;
    logic [7:0]  len;
    logic [7:0]  cnt;
    logic [7:0]  wcnt;
    logic [7:0]  base;
    logic        bad;
    logic        cp_v;
    logic [15:0] ptr;
    logic        fw_ack;
    logic        fw_rdy;
    logic [15:0] n2;
    logic [15:0] rd_word;
    logic        rd_valid;
    logic        done;
    logic        err;
    logic        upd_prev;
    logic        pend;
    logic [15:0] param;
  } ahp_regs_t;

  localparam ahp_regs_t AHP_REGS_RESET = '{
    st: AHP_IDLE, ptr: AHP_PTR_RESET, default: '0};

endpackage

// *** hw/ahp_port.sv ***
// Purpose: host data-exchange port to the module RAM, block and 4-word modes
// Assumes: host strobes synchronous to sys_clk, mode strap stable
// Notes:   multi-word block writes are staged and checked before any RAM word changes
//
// Behaviour
// - two-word mode moves several words per block instruction when executed
// - four-word mode moves one RAM word per handshaked access
// - single-word block write loads only the read pointer at address 12
// - multi-word write: first word is start address, rest stored onward
// - multi-word block write never changes the read pointer
// - read pointer holds until next single write; cleared by reset
// - block read returns consecutive words starting at the read pointer
// - a bad start word discards the whole block write, nothing stored
// - parameters take effect only after the update bit is raised
// - four-word write stores word n then raises acknowledge bit 06
// - acknowledge bit 06 drops after host drops its bit 06
// - four-word read latches address and acknowledges on bit 06
// - four-word read places word in n+2 then raises bit 07
// - bit 07 ready drops when host raises its bit 07
module ahp_port (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        mode_four,
  input  wire logic        blk_wr_req,
  input  wire logic [7:0]  blk_wr_len,
  input  wire logic        blk_wr_valid,
  input  wire logic [15:0] blk_wr_word,
  input  wire logic        blk_rd_req,
  input  wire logic [7:0]  blk_rd_len,
  output logic             blk_busy,
  output logic             blk_done,
  output logic             blk_err,
  output logic             blk_rd_valid,
  output logic      [15:0] blk_rd_word,
  output logic      [15:0] rd_ptr,
  input  wire logic        param_update,
  output logic      [15:0] param_active,
  input  wire logic [15:0] fw_word_n,
  input  wire logic [15:0] fw_word_n1,
  output logic      [15:0] fw_word_n2,
  output logic      [15:0] fw_word_n3
);
  import ahp_pkg::*;

  ahp_regs_t q;
  ahp_regs_t d;

  logic              main_we;
  logic [AHP_AW-1:0] main_waddr;
  logic [AHP_DW-1:0] main_wdata;
  logic              main_re;
  logic [AHP_AW-1:0] main_raddr;
  logic [AHP_DW-1:0] main_rdata;
  logic              stg_we;
  logic [AHP_AW-1:0] stg_waddr;
  logic              stg_re;
  logic [AHP_AW-1:0] stg_raddr;
  logic [AHP_DW-1:0] stg_rdata;
  logic              bad_n;
  logic              fw_take;

  // 8-bit increment kept in one place so widths stay explicit
  function automatic logic [7:0] inc8(input logic [7:0] v);
    return 8'(v + 8'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // main RAM and the staging RAM that holds a write until it is checked
  ahp_ram u_main (
    .sys_clk (sys_clk),
    .we      (main_we),
    .waddr   (main_waddr),
    .wdata   (main_wdata),
    .re      (main_re),
    .raddr   (main_raddr),
    .rdata_q (main_rdata)
  );

  ahp_ram u_stage (
    .sys_clk (sys_clk),
    .we      (stg_we),
    .waddr   (stg_waddr),
    .wdata   (blk_wr_word),
    .re      (stg_re),
    .raddr   (stg_raddr),
    .rdata_q (stg_rdata)
  );

  // a four-word request is taken only once both acks are down
  assign fw_take = mode_four && (q.st == AHP_IDLE) && fw_word_n1[AHP_BIT_REQ]
                   && !q.fw_ack && !q.fw_rdy;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    d          = q;
    d.done     = 1'b0;
    d.err      = 1'b0;
    d.rd_valid = 1'b0;
    d.cp_v     = 1'b0;
    main_we    = 1'b0;
    main_waddr = '0;
    main_wdata = '0;
    main_re    = 1'b0;
    main_raddr = '0;
    stg_we     = 1'b0;
    stg_waddr  = '0;
    stg_re     = 1'b0;
    stg_raddr  = '0;
    bad_n      = q.bad;
    // four-phase releases run beside the main sequencer
    if (q.fw_ack && !fw_word_n1[AHP_BIT_REQ]) begin
      d.fw_ack = 1'b0;
    end
    if (q.fw_rdy && fw_word_n1[AHP_BIT_DAT]) begin
      d.fw_rdy = 1'b0;
    end
    case (q.st)
      AHP_IDLE: begin
        if (!mode_four && blk_wr_req) begin
          d.len = blk_wr_len;
          d.cnt = 8'h00;
          d.bad = 1'b0;
          if (blk_wr_len == 8'h00) begin
            d.err  = 1'b1;
            d.done = 1'b1;
          end else begin
            d.st = AHP_WCOL;
          end
        end else if (!mode_four && blk_rd_req) begin
          d.len  = blk_rd_len;
          d.cnt  = 8'h00;
          d.wcnt = 8'h00;
          if (blk_rd_len == 8'h00) begin
            d.done = 1'b1;
          end else begin
            d.st = AHP_BRD;
          end
        end else if (fw_take) begin
          d.fw_ack = 1'b1;
          if (fw_word_n1[AHP_BIT_RW]) begin
            main_we    = 1'b1;
            main_waddr = fw_word_n1[15:AHP_ADDR_LSB];
            main_wdata = fw_word_n;
          end else begin
            main_re    = 1'b1;
            main_raddr = fw_word_n1[15:AHP_ADDR_LSB];
            d.st       = AHP_FWRD;
          end
        end else if (q.pend) begin
          main_re    = 1'b1;
          main_raddr = AHP_PARM_ADDR;
          d.pend     = 1'b0;
          d.st       = AHP_PFETCH;
        end
      end
      AHP_WCOL: begin
        if (blk_wr_valid) begin
          if (q.cnt == 8'h00 && q.len != 8'h01) begin
            // start address must be a byte and the run must fit the RAM
            d.base = blk_wr_word[7:0];
            bad_n  = q.bad || (blk_wr_word[15:8] != 8'h00)
                     || ({1'b0, blk_wr_word[7:0]} + {1'b0, q.len}
                         > AHP_RAM_TOP);
          end else if (q.cnt != 8'h00) begin
            stg_we    = 1'b1;
            stg_waddr = 8'(q.cnt - 8'h01);
          end
          d.bad = bad_n;
          d.cnt = inc8(q.cnt);
          if (q.cnt == 8'(q.len - 8'h01)) begin
            d.cnt  = 8'h00;
            d.wcnt = 8'h00;
            if (bad_n) begin
              d.err  = 1'b1;
              d.done = 1'b1;
              d.st   = AHP_IDLE;
            end else if (q.len == 8'h01) begin
              d.ptr      = blk_wr_word;
              main_we    = 1'b1;
              main_waddr = AHP_PTR_ADDR;
              main_wdata = blk_wr_word;
              d.done     = 1'b1;
              d.st       = AHP_IDLE;
            end else begin
              d.st = AHP_WCOPY;
            end
          end
        end
      end
      AHP_WCOPY: begin
        // staging read leads the RAM write by one cycle
        if (q.cnt != 8'(q.len - 8'h01)) begin
          stg_re    = 1'b1;
          stg_raddr = q.cnt;
          d.cnt     = inc8(q.cnt);
          d.cp_v    = 1'b1;
        end
        if (q.cp_v) begin
          main_we    = 1'b1;
          main_waddr = 8'(q.base + q.wcnt);
          main_wdata = stg_rdata;
          d.wcnt     = inc8(q.wcnt);
          if (q.wcnt == 8'(q.len - 8'h02)) begin
            d.done = 1'b1;
            d.st   = AHP_IDLE;
          end
        end
      end
      AHP_BRD: begin
        if (q.cnt != q.len) begin
          main_re    = 1'b1;
          main_raddr = 8'(q.ptr[7:0] + q.cnt);
          d.cnt      = inc8(q.cnt);
          d.cp_v     = 1'b1;
        end
        if (q.cp_v) begin
          d.rd_word  = main_rdata;
          d.rd_valid = 1'b1;
          d.wcnt     = inc8(q.wcnt);
          if (q.wcnt == 8'(q.len - 8'h01)) begin
            d.done = 1'b1;
            d.st   = AHP_IDLE;
          end
        end
      end
      AHP_FWRD: begin
        d.n2     = main_rdata;
        d.fw_rdy = 1'b1;
        d.st     = AHP_IDLE;
      end
      AHP_PFETCH: begin
        d.param = main_rdata;
        d.st    = AHP_IDLE;
      end
      default: begin
        d.st = AHP_IDLE;
      end
    endcase
    // a new update edge wins over the clear of the pending flag
    if (param_update && !q.upd_prev) begin
      d.pend = 1'b1;
    end
    d.upd_prev = param_update;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; pointer returns to its reset value on restart
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= AHP_REGS_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign blk_busy     = (q.st != AHP_IDLE) && (q.st != AHP_FWRD);
  assign blk_done     = q.done;
  assign blk_err      = q.err;
  assign blk_rd_valid = q.rd_valid;
  assign blk_rd_word  = q.rd_word;
  assign rd_ptr       = q.ptr;
  assign param_active = q.param;
  assign fw_word_n2   = q.n2;
  assign fw_word_n3   = {8'h00, q.fw_rdy, q.fw_ack, 6'h00};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_fw_rd_req;
    fw_take && !fw_word_n1[AHP_BIT_RW];
  endsequence

  sequence s_fw_rd_done;
    (q.st == AHP_FWRD) ##1 (q.fw_rdy && q.n2 == $past(main_rdata));
  endsequence

  a_single_ptr_load: assert property (
    (q.st == AHP_WCOL && blk_wr_valid && q.len == 8'h01 && !bad_n)
    |=> (q.ptr == $past(blk_wr_word)) && q.done)
    else $error("single word write did not load the read pointer");

  a_multi_ptr_keep: assert property (
    (q.st == AHP_WCOPY) |=> $stable(q.ptr))
    else $error("multi word write changed the read pointer");

  a_reject_no_write: assert property (
    (q.st == AHP_WCOL && q.bad) |-> !main_we)
    else $error("rejected block write touched RAM");

  a_copy_addr_seq: assert property (
    (q.st == AHP_WCOPY && q.cp_v)
    |-> main_we && main_waddr == 8'(q.base + q.wcnt))
    else $error("block write word stored at wrong address");

  a_read_from_ptr: assert property (
    (q.st == AHP_BRD && main_re)
    |-> main_raddr == 8'(q.ptr[7:0] + q.cnt) ##2 q.rd_valid[*1])
    else $error("block read address not relative to pointer");

  a_fw_write_ack: assert property (
    (fw_take && fw_word_n1[AHP_BIT_RW])
    |-> (main_we && main_waddr == fw_word_n1[15:8]) ##1 q.fw_ack)
    else $error("four word write not stored and acknowledged");

  a_fw_ack_drop: assert property (
    (q.fw_ack && !fw_word_n1[AHP_BIT_REQ]) |=> !q.fw_ack)
    else $error("acknowledge did not follow request release");

  a_fw_read_ready: assert property (
    s_fw_rd_req |=> s_fw_rd_done)
    else $error("four word read data not returned with ready");

  a_fw_rdy_drop: assert property (
    (q.fw_rdy && fw_word_n1[AHP_BIT_DAT]) |=> !q.fw_rdy)
    else $error("data ready did not drop after host took data");

  a_param_only_update: assert property (
    !$stable(q.param) |-> $past(q.st) == AHP_PFETCH)
    else $error("active parameter changed without update");

  a_fw_no_overlap: assert property (
    (mode_four && (q.fw_ack || q.fw_rdy)) |-> !main_we)
    else $error("four word request taken before release");

endmodule // ahp_port

// *** hw/ahp_ram.sv ***
// Purpose: 256 x 16 simple dual-port RAM with registered read data
// Assumes: one write and one read port, same clock
// Notes:   read data appears the cycle after re; contents not reset
module ahp_ram (
  input  wire logic                      sys_clk,
  input  wire logic                      we,
  input  wire logic [ahp_pkg::AHP_AW-1:0] waddr,
  input  wire logic [ahp_pkg::AHP_DW-1:0] wdata,
  input  wire logic                      re,
  input  wire logic [ahp_pkg::AHP_AW-1:0] raddr,
  output logic      [ahp_pkg::AHP_DW-1:0] rdata_q
);
  import ahp_pkg::*;

  logic [AHP_DW-1:0] mem [AHP_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // read first, a same-address read returns the old word; read holds last value when idle
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata_q <= mem[raddr];
    end
  end

endmodule // ahp_ram

// *** testbench/ahp_host_model.sv ***
// Purpose: controller side of the four-word handshake through words n..n+3
// Assumes: host words change at the falling clock edge
// Notes:   word n is inverted once taken, the host no longer holds it
module ahp_host_model (
  input  wire logic        sys_clk,
  output logic      [15:0] fw_word_n,
  output logic      [15:0] fw_word_n1,
  input  wire logic [15:0] fw_word_n2,
  input  wire logic [15:0] fw_word_n3
);
  timeunit 1ns;
  timeprecision 1ps;
  int stalls;

  ////////////////////////////////////////////////////////////////////////////
  // host words start cleared, no request pending
  initial begin
    fw_word_n  = 16'h0000;
    fw_word_n1 = 16'h0000;
    stalls     = 0;
  end

  // bounded wait on one flag of word n+3; a stuck flag is counted
  task automatic wait_n3(input int b, input logic v);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge sys_clk);
      ok = (fw_word_n3[b] === v);
    end
    if (!ok) stalls++;
  endtask

  // one access; slow adds cycles between address setup and request
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [15:0] d, input int slow);
    @(negedge sys_clk);
    fw_word_n  = d;
    fw_word_n1 = {a, 7'h00, wr};
    repeat (1 + slow) @(negedge sys_clk);
    fw_word_n1[6] = 1'b1;
    wait_n3(6, 1'b1);
    fw_word_n1[6] = 1'b0;
    fw_word_n     = ~d;
    wait_n3(6, 1'b0);
    if (!wr) begin
      wait_n3(7, 1'b1);
      fw_word_n1[7] = 1'b1;
      wait_n3(7, 1'b0);
      fw_word_n1[7] = 1'b0;
    end
  endtask
endmodule // ahp_host_model

// *** testbench/test_ahp_port.sv ***
// Purpose: self-checking bench of the host RAM port, both modes
// Assumes: inputs change at the falling clock edge
// Notes:   drivers queue expected words, a monitor compares them
module test_ahp_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst, mode_four, wr_req, wr_valid, rd_req, upd;
  logic        busy, done, err, rd_valid, n3_7_q;
  logic [7:0]  wr_len, rd_len, ptr_e;
  logic [15:0] wr_word, fw_n, fw_n1, fw_n2, fw_n3, rd_word, ptr, par;
  logic [15:0] exp_q[$], mem[0:255], wbuf[0:15];
  logic        err_q[$];
  int          error_cnt, comparisons, seed;

  ahp_port u_dut (.sys_clk(sys_clk), .rst(rst), .mode_four(mode_four),
    .blk_wr_req(wr_req), .blk_wr_len(wr_len), .blk_wr_valid(wr_valid),
    .blk_wr_word(wr_word), .blk_rd_req(rd_req), .blk_rd_len(rd_len),
    .blk_busy(busy), .blk_done(done), .blk_err(err),
    .blk_rd_valid(rd_valid), .blk_rd_word(rd_word), .rd_ptr(ptr),
    .param_update(upd), .param_active(par), .fw_word_n(fw_n),
    .fw_word_n1(fw_n1), .fw_word_n2(fw_n2), .fw_word_n3(fw_n3));
  ahp_host_model u_host (.sys_clk(sys_clk), .fw_word_n(fw_n),
    .fw_word_n1(fw_n1), .fw_word_n2(fw_n2), .fw_word_n3(fw_n3));

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // compared at the falling edge, once the outputs have settled
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) check(rd_word, exp_q.pop_front());
    if (fw_n3[7] === 1'b1 && n3_7_q !== 1'b1)
      check(fw_n2, exp_q.pop_front());
    if (done === 1'b1) check({15'h0, err}, {15'h0, err_q.pop_front()});
    n3_7_q <= fw_n3[7];
  end

  ////////////////////////////////////////////////////////////////////////////
  // bounded wait for the end of a block instruction, then one spare cycle
  task automatic wait_done;
    int i;
    i = 0;
    while (done !== 1'b1 && i < 50) begin
      @(negedge sys_clk);
      i++;
    end
    if (i == 50) error_cnt++;
    @(negedge sys_clk);
    check({15'h0, busy}, 16'h0000);
  endtask

  task automatic blk_write(input int m, input logic e);
    @(negedge sys_clk);
    err_q.push_back(e);
    wr_req = 1'b1;
    wr_len = 8'(m);
    for (int i = 0; i < m; i++) begin
      @(negedge sys_clk);
      wr_req   = 1'b0;
      if (i == 0) check({15'h0, busy}, 16'h0001);
      wr_valid = 1'b1;
      wr_word  = wbuf[i];
    end
    @(negedge sys_clk);
    wr_req   = 1'b0;
    wr_valid = 1'b0;
    wr_word  = ~wr_word;
    for (int i = 1; i < m && !e; i++) mem[8'(wbuf[0] + i - 1)] = wbuf[i];
    wait_done();
  endtask

  task automatic blk_read(input int m);
    @(negedge sys_clk);
    err_q.push_back(1'b0);
    for (int k = 0; k < m; k++) exp_q.push_back(mem[8'(ptr_e + k)]);
    rd_req = 1'b1;
    rd_len = 8'(m);
    @(negedge sys_clk);
    rd_req = 1'b0;
    check({15'h0, busy}, 16'h0001);
    wait_done();
  endtask

  // watchdog at 20000 cycles, far beyond the few hundred cycles the run needs
  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'he032;
    {rst, mode_four, wr_req, wr_valid, rd_req, upd} = 6'h20;
    {wr_len, rd_len, wr_word} = 32'h0;
    n3_7_q = 1'b0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    check(ptr, 16'h0000);
    check(par, 16'h0000);
    wbuf[0] = 16'h0002;
    for (int i = 1; i < 12; i++) wbuf[i] = 16'($random(seed));
    blk_write(12, 1'b0);
    wbuf[0] = 16'h0003;
    blk_write(1, 1'b0);
    ptr_e = 8'h03;
    mem[12] = 16'h0003;
    check(ptr, 16'h0003);
    wbuf[0] = 16'h0040;
    blk_write(3, 1'b0);
    check(ptr, 16'h0003);
    for (int j = 0; j < 3; j++) begin
      wbuf[0] = (j == 0) ? 16'h00FE : 16'h0105;
      for (int i = 1; i < 4; i++) wbuf[i] = 16'($random(seed));
      blk_write((j == 2) ? 0 : 4 - j, 1'b1);
    end
    blk_read(10);
    ptr_e = 8'h40;
    wbuf[0] = 16'h0040;
    blk_write(1, 1'b0);
    mem[12] = 16'h0040;
    blk_read(2);
    mode_four = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ptr_e = 8'($random(seed)) | 8'h80;
      wbuf[0] = 16'($random(seed));
      u_host.access(1'b1, ptr_e, wbuf[0], i);
      exp_q.push_back(wbuf[0]);
      u_host.access(1'b0, ptr_e, 16'h0000, i % 2);
    end
    exp_q.push_back(mem[5]);
    u_host.access(1'b0, 8'h05, 16'h0000, 0);
    u_host.access(1'b1, 8'h00, 16'h5A3C, 0);
    mode_four = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(par, 16'h0000);
    upd = 1'b1;
    for (int i = 0; i < 20 && par !== 16'h5A3C; i++) @(negedge sys_clk);
    check(par, 16'h5A3C);
    upd = 1'b0;
    check(16'(u_host.stalls), 16'h0000);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    check(ptr, 16'h0000);
    end_of_test();
  end
endmodule // test_ahp_port
